/* hw/csa_cell_compare.v */
// Purpose: Per-sample hysteresis comparison of one cell reading against its thresholds.
// Assumes: Bipolar codes are offset binary, so 0x3fff is the largest and 0x0000 the least.
// Notes: Purely combinational; the caller holds the alert state.
`timescale 1ns/10ps
module csa_cell_compare #(
    parameter DW = 14
) (
    input wire [DW-1:0] sample,
    input wire bipolar,
    input wire [DW-1:0] uni_high_set,
    input wire [DW-1:0] uni_high_clr,
    input wire [DW-1:0] uni_low_set,
    input wire [DW-1:0] uni_low_clr,
    input wire [DW-1:0] bip_high_set,
    input wire [DW-1:0] bip_high_clr,
    input wire [DW-1:0] bip_low_set,
    input wire [DW-1:0] bip_low_clr,
    input wire high_now,
    input wire low_now,
    output reg high_next,
    output reg low_next,
    output wire signed [DW:0] sample_ext
);

    // Maps a code onto one signed scale; bipolar codes are shifted down by half range.
    function signed [DW:0] csa_ext;
        input [DW-1:0] v;
        input bip;
        begin
            if (bip) begin
                csa_ext = {{2{~v[DW-1]}}, v[DW-2:0]};
            end else begin
                csa_ext = {1'b0, v};
            end
        end
    endfunction

    wire signed [DW:0] hs;
    wire signed [DW:0] hc;
    wire signed [DW:0] ls;
    wire signed [DW:0] lc;

    assign hs = csa_ext(bipolar ? bip_high_set : uni_high_set, bipolar);
    assign hc = csa_ext(bipolar ? bip_high_clr : uni_high_clr, bipolar);
    assign ls = csa_ext(bipolar ? bip_low_set : uni_low_set, bipolar);
    assign lc = csa_ext(bipolar ? bip_low_clr : uni_low_clr, bipolar);
    assign sample_ext = csa_ext(sample, bipolar);

    // Overvoltage hysteresis: strictly above set asserts, at or below clear releases.
    always @* begin
        high_next = high_now;
        if (sample_ext > hs) begin
            high_next = 1'b1;
        end else if (sample_ext <= hc) begin
            high_next = 1'b0;
        end
    end

    // Undervoltage hysteresis: strictly below set asserts, at or above clear releases.
    always @* begin
        low_next = low_now;
        if (sample_ext < ls) begin
            low_next = 1'b1;
        end else if (sample_ext >= lc) begin
            low_next = 1'b0;
        end
    end

endmodule // csa_cell_compare

/* hw/csa_defines.vh */
// Purpose: Shared constants for the cell spread and bipolar alert threshold bank.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: Threshold fields are 14 bits wide and sit in bits 15 down to 2.
`ifndef CSA_DEFINES_VH
`define CSA_DEFINES_VH

// Register word indices.
`define CSA_IDX_SPREAD_LIMIT 10'h023
`define CSA_IDX_BIP_HIGH_CLR 10'h024
`define CSA_IDX_BIP_HIGH_SET 10'h025
`define CSA_IDX_BIP_LOW_CLR 10'h026
`define CSA_IDX_BIP_LOW_SET 10'h027
`define CSA_IDX_CONTROL 10'h040
`define CSA_IDX_IRQ_STATUS 10'h041
`define CSA_IDX_IRQ_MASK 10'h042
`define CSA_IDX_ALERT_STATE 10'h043

// Threshold field position inside a register.
`define CSA_FLD_MSB 15
`define CSA_FLD_LSB 2

// Reset values of the 14-bit threshold fields.
`define CSA_RST_SPREAD_LIMIT 14'h3fff
`define CSA_RST_BIP_HIGH_CLR 14'h3fff
`define CSA_RST_BIP_HIGH_SET 14'h3fff
`define CSA_RST_BIP_LOW_CLR 14'h0000
`define CSA_RST_BIP_LOW_SET 14'h0000

// Control register: bit that widens the spread scope to every cell.
`define CSA_CTL_SCOPE_BIT 0
`define CSA_RST_CONTROL 1'h0

// Interrupt status and mask bit positions, and their reset values.
`define CSA_EV_HIGH_BIT 0
`define CSA_EV_LOW_BIT 1
`define CSA_EV_SPREAD_BIT 2
`define CSA_RST_IRQ_STATUS 3'h0
`define CSA_RST_IRQ_MASK 3'h0

// Bus response codes.
`define CSA_RESP_OKAY 2'h0
`define CSA_RESP_SLVERR 2'h2

`endif

/* hw/csa_threshold_bank.v */
// Purpose: Cell spread and bipolar over/undervoltage threshold bank on AXI4-Lite.
// Assumes: Measurement results arrive on aclk from the scan engine, one per valid cycle.
// Notes: Alerts hold per cell with hysteresis; the spread alert updates at each scan end.
//
// Contract
// - Spread limit register: 14-bit field in bits 15:2, resets all ones.
// - Spread alert asserts when largest minus smallest reading exceeds the limit.
// - A scope bit picks unipolar-only cells or all cells for spread.
// - Bipolar high alert clears at or below the bipolar high clear level.
// - Bipolar high alert sets strictly above the bipolar high set level.
// - A high set level of 0x3fff effectively disables bipolar high checks.
// - Bipolar low alert clears at or above the bipolar low clear level.
// - Bipolar low alert sets strictly below the bipolar low set level.
// - A low set level of zero effectively disables bipolar low checks.
// - Bipolar levels are read in the bipolar result format.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "csa_defines.vh"
module csa_threshold_bank #(
    parameter NCELL = 14,
    parameter CELL_W = 4,
    parameter DW = 14,
    parameter ADDR_W = 12
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire meas_valid,
    input wire [CELL_W-1:0] meas_cell,
    input wire [DW-1:0] meas_data,
    input wire cell_polarity_select,
    input wire meas_last,
    input wire [DW-1:0] uni_high_set_value,
    input wire [DW-1:0] uni_high_clear_value,
    input wire [DW-1:0] uni_low_set_value,
    input wire [DW-1:0] uni_low_clear_value,
    output reg [NCELL-1:0] cell_high_flags,
    output reg [NCELL-1:0] cell_low_flags,
    output reg cell_overvoltage_alert,
    output reg cell_undervoltage_alert,
    output reg cell_spread_alert,
    output reg irq
);

    // Threshold fields, control, interrupt state and spread tracking.
    reg [DW-1:0] spread_limit_value;
    reg [DW-1:0] bipolar_high_clear_value;
    reg [DW-1:0] bipolar_high_set_value;
    reg [DW-1:0] bipolar_low_clear_value;
    reg [DW-1:0] bipolar_low_set_value;
    reg spread_scope_select;
    reg [2:0] irq_status_reg;
    reg [2:0] irq_mask_reg;
    reg signed [DW:0] max_reg;
    reg signed [DW:0] min_reg;
    reg seen_reg;
    reg [ADDR_W-1:0] wr_addr_reg;
    reg [31:0] wr_data_reg;
    reg [3:0] wr_strb_reg;
    reg aw_have_reg;
    reg w_have_reg;

    // Combinational results of the current sample.
    reg [NCELL-1:0] high_next;
    reg [NCELL-1:0] low_next;
    reg [2:0] ev_set;
    reg signed [DW:0] max_next;
    reg signed [DW:0] min_next;
    reg seen_next;
    reg [DW+1:0] spread_diff;
    reg [31:0] rd_word;
    reg rd_hit;
    reg wr_hit;
    reg [2:0] status_next;
    wire cmp_high;
    wire cmp_low;
    wire signed [DW:0] sample_ext;
    wire cell_ok;
    wire high_now;
    wire low_now;
    wire sample_in;
    wire wr_fire;
    wire [9:0] wr_idx;
    wire [9:0] rd_idx;

    // Places a threshold field in its register bits; bits 1:0 stay zero.
    function [31:0] csa_field_rd;
        input [DW-1:0] v;
        begin
            csa_field_rd = {16'h0000, v, 2'h0};
        end
    endfunction

    // Merges written byte lanes into a threshold field; bits 1:0 are dropped.
    function [DW-1:0] csa_field_wr;
        input [DW-1:0] old;
        input [31:0] d;
        input [3:0] s;
        reg [15:0] w;
        begin
            w = {old, 2'h0};
            if (s[0]) begin
                w[7:0] = d[7:0];
            end
            if (s[1]) begin
                w[15:8] = d[15:8];
            end
            csa_field_wr = w[`CSA_FLD_MSB:`CSA_FLD_LSB];
        end
    endfunction

    assign cell_ok = meas_valid && (meas_cell < NCELL);
    assign high_now = cell_ok ? cell_high_flags[meas_cell] : 1'b0;
    assign low_now = cell_ok ? cell_low_flags[meas_cell] : 1'b0;
    assign sample_in = meas_valid && (spread_scope_select || !cell_polarity_select);
    assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_idx = wr_addr_reg[11:2];
    assign rd_idx = s_axi_araddr[11:2];

    // Threshold comparison for the sample on the measurement port.
    csa_cell_compare #(
        .DW(DW)
    ) u_cmp (
        .sample(meas_data),
        .bipolar(cell_polarity_select),
        .uni_high_set(uni_high_set_value),
        .uni_high_clr(uni_high_clear_value),
        .uni_low_set(uni_low_set_value),
        .uni_low_clr(uni_low_clear_value),
        .bip_high_set(bipolar_high_set_value),
        .bip_high_clr(bipolar_high_clear_value),
        .bip_low_set(bipolar_low_set_value),
        .bip_low_clr(bipolar_low_clear_value),
        .high_now(high_now),
        .low_now(low_now),
        .high_next(cmp_high),
        .low_next(cmp_low),
        .sample_ext(sample_ext)
    );

    // Next per-cell flags, running extremes, spread and rising-edge events.
    always @* begin
        high_next = cell_high_flags;
        low_next = cell_low_flags;
        max_next = max_reg;
        min_next = min_reg;
        seen_next = seen_reg;
        ev_set = 3'h0;
        if (cell_ok) begin
            high_next[meas_cell] = cmp_high;
            low_next[meas_cell] = cmp_low;
            ev_set[`CSA_EV_HIGH_BIT] = cmp_high && !high_now;
            ev_set[`CSA_EV_LOW_BIT] = cmp_low && !low_now;
        end
        if (sample_in) begin
            if (!seen_reg || sample_ext > max_reg) begin
                max_next = sample_ext;
            end
            if (!seen_reg || sample_ext < min_reg) begin
                min_next = sample_ext;
            end
            seen_next = 1'b1;
        end
        spread_diff = {max_next[DW], max_next} - {min_next[DW], min_next};
        if (meas_valid && meas_last) begin
            ev_set[`CSA_EV_SPREAD_BIT] = seen_next && !cell_spread_alert &&
                (spread_diff > {2'h0, spread_limit_value});
        end
    end

    // Interrupt status: hardware set wins over a one written to clear.
    always @* begin
        status_next = irq_status_reg;
        if (wr_fire && wr_idx == `CSA_IDX_IRQ_STATUS && wr_strb_reg[0]) begin
            status_next = irq_status_reg & ~wr_data_reg[2:0];
        end
        status_next = status_next | ev_set;
    end

    // Alert state, spread tracking and the interrupt line.
    always @(posedge aclk) begin
        if (!aresetn) begin
            cell_high_flags <= {NCELL{1'b0}};
            cell_low_flags <= {NCELL{1'b0}};
            cell_overvoltage_alert <= 1'b0;
            cell_undervoltage_alert <= 1'b0;
            cell_spread_alert <= 1'b0;
            max_reg <= {(DW+1){1'b0}};
            min_reg <= {(DW+1){1'b0}};
            seen_reg <= 1'b0;
            irq_status_reg <= `CSA_RST_IRQ_STATUS;
            irq <= 1'b0;
        end else begin
            cell_high_flags <= high_next;
            cell_low_flags <= low_next;
            cell_overvoltage_alert <= |high_next;
            cell_undervoltage_alert <= |low_next;
            irq_status_reg <= status_next;
            irq <= |(status_next & irq_mask_reg);
            if (meas_valid && meas_last) begin
                cell_spread_alert <= seen_next && (spread_diff > {2'h0, spread_limit_value});
                seen_reg <= 1'b0;
            end else begin
                max_reg <= max_next;
                min_reg <= min_next;
                seen_reg <= seen_next;
            end
        end
    end

    // Write channel: address and data are taken in either order, then applied together.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSA_RESP_OKAY;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            wr_addr_reg <= {ADDR_W{1'b0}};
            wr_data_reg <= 32'h0000_0000;
            wr_strb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr_reg <= s_axi_awaddr;
                aw_have_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data_reg <= s_axi_wdata;
                wr_strb_reg <= s_axi_wstrb;
                w_have_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `CSA_RESP_OKAY : `CSA_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write decode: flags whether the held address names a register.
    always @* begin
        case (wr_idx)
            `CSA_IDX_SPREAD_LIMIT, `CSA_IDX_BIP_HIGH_CLR, `CSA_IDX_BIP_HIGH_SET,
            `CSA_IDX_BIP_LOW_CLR, `CSA_IDX_BIP_LOW_SET, `CSA_IDX_CONTROL,
            `CSA_IDX_IRQ_STATUS, `CSA_IDX_IRQ_MASK, `CSA_IDX_ALERT_STATE: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // Software-writable threshold and control registers.
    always @(posedge aclk) begin
        if (!aresetn) begin
            spread_limit_value <= `CSA_RST_SPREAD_LIMIT;
            bipolar_high_clear_value <= `CSA_RST_BIP_HIGH_CLR;
            bipolar_high_set_value <= `CSA_RST_BIP_HIGH_SET;
            bipolar_low_clear_value <= `CSA_RST_BIP_LOW_CLR;
            bipolar_low_set_value <= `CSA_RST_BIP_LOW_SET;
            spread_scope_select <= `CSA_RST_CONTROL;
            irq_mask_reg <= `CSA_RST_IRQ_MASK;
        end else if (wr_fire) begin
            case (wr_idx)
                `CSA_IDX_SPREAD_LIMIT: begin
                    spread_limit_value <= csa_field_wr(spread_limit_value, wr_data_reg,
                        wr_strb_reg);
                end
                `CSA_IDX_BIP_HIGH_CLR: begin
                    bipolar_high_clear_value <= csa_field_wr(bipolar_high_clear_value,
                        wr_data_reg, wr_strb_reg);
                end
                `CSA_IDX_BIP_HIGH_SET: begin
                    bipolar_high_set_value <= csa_field_wr(bipolar_high_set_value,
                        wr_data_reg, wr_strb_reg);
                end
                `CSA_IDX_BIP_LOW_CLR: begin
                    bipolar_low_clear_value <= csa_field_wr(bipolar_low_clear_value,
                        wr_data_reg, wr_strb_reg);
                end
                `CSA_IDX_BIP_LOW_SET: begin
                    bipolar_low_set_value <= csa_field_wr(bipolar_low_set_value,
                        wr_data_reg, wr_strb_reg);
                end
                `CSA_IDX_CONTROL: begin
                    if (wr_strb_reg[0]) begin
                        spread_scope_select <= wr_data_reg[`CSA_CTL_SCOPE_BIT];
                    end
                end
                `CSA_IDX_IRQ_MASK: begin
                    if (wr_strb_reg[0]) begin
                        irq_mask_reg <= wr_data_reg[2:0];
                    end
                end
                default: begin
                    spread_scope_select <= spread_scope_select;
                end
            endcase
        end
    end

    // Read decode of the requested address.
    always @* begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        case (rd_idx)
            `CSA_IDX_SPREAD_LIMIT: rd_word = csa_field_rd(spread_limit_value);
            `CSA_IDX_BIP_HIGH_CLR: rd_word = csa_field_rd(bipolar_high_clear_value);
            `CSA_IDX_BIP_HIGH_SET: rd_word = csa_field_rd(bipolar_high_set_value);
            `CSA_IDX_BIP_LOW_CLR: rd_word = csa_field_rd(bipolar_low_clear_value);
            `CSA_IDX_BIP_LOW_SET: rd_word = csa_field_rd(bipolar_low_set_value);
            `CSA_IDX_CONTROL: rd_word = {31'h0, spread_scope_select};
            `CSA_IDX_IRQ_STATUS: rd_word = {29'h0, irq_status_reg};
            `CSA_IDX_IRQ_MASK: rd_word = {29'h0, irq_mask_reg};
            `CSA_IDX_ALERT_STATE: begin
                rd_word = {29'h0, cell_spread_alert, cell_undervoltage_alert,
                    cell_overvoltage_alert};
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: one read at a time, answered the cycle after the address is taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CSA_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `CSA_RESP_OKAY : `CSA_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // csa_threshold_bank

/* verification/csa_bank_properties.sv */
// Purpose: Concurrent checks on the threshold bank alert outputs.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Registers are unseen here, so only code-independent cases are judged.
`timescale 1ns/10ps
module csa_bank_checker #(
    parameter NCELL = 14,
    parameter CELL_W = 4,
    parameter DW = 14
) (
    input wire aclk,
    input wire aresetn,
    input wire meas_valid,
    input wire [CELL_W-1:0] meas_cell,
    input wire [DW-1:0] meas_data,
    input wire cell_polarity_select,
    input wire meas_last,
    input wire [DW-1:0] uni_high_set_value,
    input wire [DW-1:0] uni_low_set_value,
    input wire [NCELL-1:0] cell_high_flags,
    input wire [NCELL-1:0] cell_low_flags,
    input wire cell_overvoltage_alert,
    input wire cell_undervoltage_alert,
    input wire cell_spread_alert
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // A sample for a real cell, split by its polarity.
    sequence s_cell;
        meas_valid && meas_cell < NCELL;
    endsequence
    sequence s_uni;
        s_cell ##0 !cell_polarity_select;
    endsequence
    sequence s_bip;
        s_cell ##0 cell_polarity_select;
    endsequence
    // Summary alerts mirror the flag vectors.
    ov_sum_a: assert property (cell_overvoltage_alert == |cell_high_flags)
        else $error("over summary wrong");
    uv_sum_a: assert property (cell_undervoltage_alert == |cell_low_flags)
        else $error("under summary wrong");
    // Unipolar samples are judged against the unipolar set levels.
    uni_high_a: assert property (s_uni ##0 (meas_data > uni_high_set_value)
        |=> cell_high_flags[$past(meas_cell)]) else $error("unipolar high not set");
    uni_low_a: assert property (s_uni ##0 (meas_data < uni_low_set_value)
        |=> cell_low_flags[$past(meas_cell)]) else $error("unipolar low not set");
    // The bipolar floor and ceiling codes always clear the opposite flag.
    bip_floor_a: assert property (s_bip ##0 (meas_data == '0)
        |=> !cell_high_flags[$past(meas_cell)]) else $error("high flag kept at floor");
    bip_ceil_a: assert property (s_bip ##0 (&meas_data)
        |=> !cell_low_flags[$past(meas_cell)]) else $error("low flag kept at ceiling");
    // Alerts move only on samples and scan ends.
    spread_hold_a: assert property (!(meas_valid && meas_last)
        |=> $stable(cell_spread_alert)) else $error("spread alert moved mid-scan");
    flag_hold_a: assert property (!meas_valid
        |=> $stable(cell_high_flags) && $stable(cell_low_flags)) else $error("flags moved");
endmodule // csa_bank_checker

/* verification/csa_threshold_bank_test.sv */
// Purpose: Self-checking bench for the cell spread and bipolar threshold bank.
// Assumes: Byte address is four times the word index; fields sit in bits 15:2.
// Notes: Each scenario task drives the block and judges what comes back.
`timescale 1ns/10ps
module csa_threshold_bank_test;
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic meas_valid = 1'h0, meas_last = 1'h0, cell_polarity_select = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf, meas_cell = 4'h0;
    logic [13:0] meas_data = 14'h0, uni_high_set_value = 14'h3fff, uni_low_set_value = 14'h0;
    logic [13:0] uni_high_clear_value = 14'h3fff, uni_low_clear_value = 14'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [13:0] hf, lf;
    wire ova, uva, spa;
    int errors = 0, n_compared = 0;
    // Block under test.
    csa_threshold_bank i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas_valid, .meas_cell, .meas_data,
        .cell_polarity_select, .meas_last, .uni_high_set_value, .uni_high_clear_value,
        .uni_low_set_value, .uni_low_clear_value, .cell_high_flags(hf), .cell_low_flags(lf),
        .cell_overvoltage_alert(ova), .cell_undervoltage_alert(uva),
        .cell_spread_alert(spa), .irq
    );
    // Free-running 50 MHz clock.
    always #10 aclk = ~aclk;
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 99) begin
            errors++;
            $display("[ERR] handshake expected in 99 cycles seen none");
            wrap_up;
        end
    endtask
    // Write with address and data offered together; bready held until bvalid.
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 99);
        s_axi_bready <= 1'h0;
        tmo(n);
        chk("bresp", er, s_axi_bresp);
    endtask
    // Read; rdata and rresp are taken at the edge where rvalid is seen.
    task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 99);
        s_axi_rready <= 1'h0;
        tmo(n);
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask
    function automatic logic [11:0] ad(input int k);
        return 12'h08c + 12'(4 * k);
    endfunction
    task automatic wt(input int k, input logic [13:0] v);
        axw(ad(k), {16'h0, v, 2'h0}, 2'h0);
    endtask
    // One cell result; pl is {polarity, last}.
    task automatic ms(input logic [3:0] c, input logic [13:0] d, input logic [1:0] pl);
        meas_valid <= 1'h1;
        meas_cell <= c;
        meas_data <= d;
        {cell_polarity_select, meas_last} <= pl;
        @(posedge aclk);
        meas_valid <= 1'h0;
        meas_last <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic t_regs;
        logic [31:0] rv [5] = '{32'hfffc, 32'hfffc, 32'hfffc, 32'h0, 32'h0};
        for (int i = 0; i < 5; i++) axr(ad(i), rv[i], 2'h0);
        axr(12'h3fc, 32'h0, 2'h2);
        axw(12'h3fc, 32'hffff, 2'h2);
        for (int i = 0; i < 5; i++) begin
            axw(ad(i), 32'hffffffff, 2'h0);
            axr(ad(i), 32'h0000fffc, 2'h0);
        end
        $display("t_regs end");
    endtask
    task automatic t_high;
        wt(2, 14'h3000);
        wt(1, 14'h2800);
        ms(4'h3, 14'h3000, 2'h2);
        chk("high3", 1'h0, hf[3]);
        ms(4'h3, 14'h3001, 2'h2);
        chk("high3", 1'h1, hf[3]);
        chk("ov", 1'h1, ova);
        ms(4'h3, 14'h2801, 2'h2);
        chk("high3", 1'h1, hf[3]);
        ms(4'h3, 14'h2800, 2'h2);
        chk("high3", 1'h0, hf[3]);
        chk("ov", 1'h0, ova);
        ms(4'h3, 14'h3001, 2'h0);
        chk("high3", 1'h0, hf[3]);
        uni_high_set_value <= 14'h2000;
        uni_low_set_value <= 14'h0800;
        ms(4'h5, 14'h3001, 2'h0);
        ms(4'h6, 14'h0100, 2'h0);
        chk("high5", 1'h1, hf[5]);
        chk("low6", 1'h1, lf[6]);
        ms(4'h5, 14'h1000, 2'h0);
        ms(4'h6, 14'h1000, 2'h0);
        chk("low6", 1'h0, lf[6]);
        wt(2, 14'h3fff);
        wt(1, 14'h3fff);
        ms(4'h3, 14'h3fff, 2'h2);
        chk("high3", 1'h0, hf[3]);
        $display("t_high end");
    endtask
    task automatic t_low;
        wt(4, 14'h1000);
        wt(3, 14'h1800);
        ms(4'h2, 14'h1000, 2'h2);
        chk("low2", 1'h0, lf[2]);
        chk("uv", 1'h0, uva);
        ms(4'h2, 14'h0fff, 2'h2);
        chk("low2", 1'h1, lf[2]);
        chk("uv", 1'h1, uva);
        ms(4'h2, 14'h17ff, 2'h2);
        chk("low2", 1'h1, lf[2]);
        ms(4'h2, 14'h1800, 2'h2);
        chk("low2", 1'h0, lf[2]);
        wt(4, 14'h0);
        wt(3, 14'h0);
        ms(4'h2, 14'h0, 2'h2);
        chk("low2", 1'h0, lf[2]);
        $display("t_low end");
    endtask
    task automatic t_spread;
        wt(0, 14'h0100);
        ms(4'h0, 14'h0, 2'h1);
        ms(4'h0, 14'h1000, 2'h0);
        ms(4'h1, 14'h1101, 2'h1);
        chk("spread", 1'h1, spa);
        axr(12'h10c, 32'h4, 2'h0);
        ms(4'h0, 14'h1000, 2'h0);
        ms(4'h1, 14'h1100, 2'h1);
        chk("spread", 1'h0, spa);
        for (int s = 0; s < 2; s++) begin
            axw(12'h100, 32'(s), 2'h0);
            ms(4'h0, 14'h1000, 2'h0);
            ms(4'h1, 14'h3fff, 2'h3);
            chk("spread", 32'(s), spa);
        end
        axw(12'h100, 32'h0, 2'h0);
        $display("t_spread end");
    endtask
    // alert event raised, cleared and masked.
    task automatic t_irq;
        axw(12'h104, 32'h7, 2'h0);
        axw(12'h108, 32'h1, 2'h0);
        wt(1, 14'h2800);
        wt(2, 14'h3000);
        ms(4'h3, 14'h3001, 2'h2);
        chk("irq", 1'h1, irq);
        axw(12'h104, 32'h1, 2'h0);
        chk("irq", 1'h0, irq);
        ms(4'h3, 14'h0, 2'h2);
        axw(12'h108, 32'h0, 2'h0);
        ms(4'h3, 14'h3001, 2'h2);
        chk("irq", 1'h0, irq);
        $display("t_irq end");
    endtask
    // Reset for three cycles, then every scenario in turn.
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_regs;
        t_high;
        t_low;
        t_spread;
        t_irq;
        wrap_up;
    end
endmodule // csa_threshold_bank_test
bind csa_threshold_bank csa_bank_checker #(.NCELL(NCELL), .CELL_W(CELL_W), .DW(DW)) i_chk (
    .aclk, .aresetn, .meas_valid, .meas_cell, .meas_data, .cell_polarity_select, .meas_last,
    .uni_high_set_value, .uni_low_set_value, .cell_high_flags, .cell_low_flags,
    .cell_overvoltage_alert, .cell_undervoltage_alert, .cell_spread_alert
);
